// ==== hdl/cis_core.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// [RQ1] call pushes pc plus one onto stack
// [RQ2] call then loads pc from latch and accumulator
// [RQ3] call takes two instruction cycles
// [RQ4] clear file zeroes register, sets zero flag
// [RQ5] clear accumulator zeroes it, sets zero flag
// [RQ6] kick clears watchdog count and prescaler
// [RQ7] kick sets expiry and sleep flags
// [RQ8] complement file to accumulator or file
// [RQ9] decrement file to accumulator or file
// [RQ10] complement/decrement update only zero flag
module cis_core
  import cis_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {CIS_IDLE, CIS_EXEC, CIS_CALL2} cis_state_t;

  function automatic logic [31:0] cis_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : cis_merge

  function automatic logic cis_is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : cis_is_zero

  cis_state_t state_r;
  cis_cmd_t cmd_r;
  logic [7:0] acc_r;
  logic [6:0] latch_r;
  logic [14:0] pc_r;
  logic zero_r;
  logic expiry_r;
  logic sleep_r;
  logic [6:0] fsel_r;
  logic [7:0] file_mem [CIS_FILE_DEPTH];
  logic [14:0] stack_mem [CIS_STACK_DEPTH];
  logic [3:0] sp_r;
  logic [7:0] wdt_cnt_r;
  logic [7:0] wdt_pre_r;

  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  logic wr_go;
  logic exec;
  logic [7:0] fval;
  logic [7:0] alu;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  // register writes wait for idle so they never race an instruction
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid
                 && (state_r == CIS_IDLE);
  assign exec = (state_r == CIS_EXEC);
  assign fval = file_mem[cmd_r.faddr];
  assign alu = (cmd_r.op == CIS_OP_COMPLEMENT_FILE) ? ~fval // RQ8
               : fval - 8'h01; // RQ9

  always_comb begin
    case (aw_addr_r)
      CIS_OFF_CMD, CIS_OFF_ACC, CIS_OFF_LATCH, CIS_OFF_PC,
      CIS_OFF_STATUS, CIS_OFF_FSEL, CIS_OFF_FDATA: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // write address and data channels, taken in either order
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CIS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? CIS_RESP_OKAY : CIS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // sequencer: a command write starts one instruction
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= CIS_IDLE;
      cmd_r <= '0;
    end else begin
      case (state_r)
        CIS_IDLE: begin
          if (wr_go && aw_addr_r == CIS_OFF_CMD && w_strb_r[0]) begin
            cmd_r <= cis_cmd_t'(w_data_r[CIS_CMD_DEST_BIT:0]);
            state_r <= CIS_EXEC;
          end
        end
        CIS_EXEC: begin
          if (cmd_r.op == CIS_OP_CALL_VIA_ACCUMULATOR) begin
            state_r <= CIS_CALL2; // RQ3
          end else begin
            state_r <= CIS_IDLE;
          end
        end
        CIS_CALL2: state_r <= CIS_IDLE;
        default: state_r <= CIS_IDLE;
      endcase
    end
  end

  // program counter and return stack
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pc_r <= CIS_PC_RST;
      sp_r <= 4'h0;
    end else if (exec) begin
      if (cmd_r.op == CIS_OP_CALL_VIA_ACCUMULATOR) begin
        stack_mem[sp_r] <= pc_r + 15'h0001; // RQ1
        sp_r <= sp_r + 4'h1; // RQ1
      end else begin
        pc_r <= pc_r + 15'h0001;
      end
    end else if (state_r == CIS_CALL2) begin
      pc_r <= {latch_r, acc_r}; // RQ2
    end else if (wr_go && aw_addr_r == CIS_OFF_PC) begin
      pc_r <= 15'(cis_merge({17'h0, pc_r}, w_data_r, w_strb_r));
    end
  end

  // accumulator and upper latch
  always_ff @(posedge clock) begin
    if (!rstn) begin
      acc_r <= CIS_ACC_RST;
      latch_r <= 7'h00;
    end else if (exec) begin
      case (cmd_r.op)
        CIS_OP_CLEAR_ACCUMULATOR: acc_r <= 8'h00; // RQ5
        CIS_OP_COMPLEMENT_FILE, CIS_OP_DECREMENT_FILE: begin
          if (!cmd_r.dest) begin
            acc_r <= alu; // RQ8 RQ9
          end
        end
        default: acc_r <= acc_r;
      endcase
    end else if (wr_go && aw_addr_r == CIS_OFF_ACC) begin
      acc_r <= 8'(cis_merge({24'h0, acc_r}, w_data_r, w_strb_r));
    end else if (wr_go && aw_addr_r == CIS_OFF_LATCH) begin
      latch_r <= 7'(cis_merge({25'h0, latch_r}, w_data_r, w_strb_r));
    end
  end

  // file registers; no reset, contents undefined until written
  always_ff @(posedge clock) begin
    if (exec) begin
      case (cmd_r.op)
        CIS_OP_CLEAR_FILE_REGISTER: file_mem[cmd_r.faddr] <= 8'h00; // RQ4
        CIS_OP_COMPLEMENT_FILE, CIS_OP_DECREMENT_FILE: begin
          if (cmd_r.dest) begin
            file_mem[cmd_r.faddr] <= alu; // RQ8 RQ9
          end
        end
        default: ;
      endcase
    end else if (wr_go && aw_addr_r == CIS_OFF_FDATA && w_strb_r[0]) begin
      file_mem[fsel_r] <= w_data_r[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      fsel_r <= 7'h00;
    end else if (wr_go && aw_addr_r == CIS_OFF_FSEL && w_strb_r[0]) begin
      fsel_r <= w_data_r[6:0];
    end
  end

  // zero flag
  always_ff @(posedge clock) begin
    if (!rstn) begin
      zero_r <= 1'b0;
    end else if (exec) begin
      case (cmd_r.op)
        CIS_OP_CLEAR_FILE_REGISTER: zero_r <= 1'b1; // RQ4
        CIS_OP_CLEAR_ACCUMULATOR: zero_r <= 1'b1; // RQ5
        CIS_OP_COMPLEMENT_FILE, CIS_OP_DECREMENT_FILE: begin
          zero_r <= cis_is_zero(alu); // RQ10
        end
        default: zero_r <= zero_r;
      endcase
    end else if (wr_go && aw_addr_r == CIS_OFF_STATUS && w_strb_r[0]) begin
      zero_r <= w_data_r[CIS_ST_ZERO];
    end
  end

  // watchdog: prescaler ticks every clock, count on prescaler wrap
  logic kick;
  logic wdt_fire;
  assign kick = exec && (cmd_r.op == CIS_OP_WATCHDOG_KICK);
  assign wdt_fire = (wdt_cnt_r == CIS_WDT_MAX) && (wdt_pre_r == CIS_WDT_MAX);

  always_ff @(posedge clock) begin
    if (!rstn || kick) begin
      wdt_cnt_r <= 8'h00; // RQ6
      wdt_pre_r <= 8'h00; // RQ6
    end else begin
      wdt_pre_r <= wdt_pre_r + 8'h01;
      if (wdt_pre_r == CIS_WDT_MAX) begin
        wdt_cnt_r <= wdt_cnt_r + 8'h01;
      end
    end
  end

  // expiry flag reads 0 after a timeout; hardware event beats sw write
  always_ff @(posedge clock) begin
    if (!rstn) begin
      expiry_r <= 1'b1;
      sleep_r <= 1'b1;
    end else if (kick) begin
      expiry_r <= 1'b1; // RQ7
      sleep_r <= 1'b1; // RQ7
    end else begin
      if (wdt_fire) begin
        expiry_r <= 1'b0;
      end else if (wr_go && aw_addr_r == CIS_OFF_STATUS && w_strb_r[0]) begin
        expiry_r <= w_data_r[CIS_ST_EXPIRY];
      end
      if (wr_go && aw_addr_r == CIS_OFF_STATUS && w_strb_r[0]) begin
        sleep_r <= w_data_r[CIS_ST_SLEEP];
      end
    end
  end

  // read channel
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      CIS_OFF_CMD: rd_val = {21'h0, cmd_r};
      CIS_OFF_ACC: rd_val = {24'h0, acc_r};
      CIS_OFF_LATCH: rd_val = {25'h0, latch_r};
      CIS_OFF_PC: rd_val = {17'h0, pc_r};
      CIS_OFF_STATUS: begin
        rd_val[CIS_ST_ZERO] = zero_r;
        rd_val[CIS_ST_EXPIRY] = expiry_r;
        rd_val[CIS_ST_SLEEP] = sleep_r;
        rd_val[CIS_ST_BUSY] = (state_r != CIS_IDLE);
      end
      CIS_OFF_FSEL: rd_val = {25'h0, fsel_r};
      CIS_OFF_FDATA: rd_val = {24'h0, file_mem[fsel_r]};
      CIS_OFF_STACK: begin
        rd_val[14:0] = stack_mem[sp_r - 4'h1];
        rd_val[CIS_STK_SP_LSB +: 4] = sp_r;
      end
      CIS_OFF_WDT: rd_val = {16'h0, wdt_pre_r, wdt_cnt_r};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CIS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? CIS_RESP_OKAY : CIS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : cis_core
`default_nettype wire

// ==== hdl/cis_pkg.sv ====
package cis_pkg;
  // register byte offsets
  localparam logic [7:0] CIS_OFF_CMD = 8'h00;
  localparam logic [7:0] CIS_OFF_ACC = 8'h04;
  localparam logic [7:0] CIS_OFF_LATCH = 8'h08;
  localparam logic [7:0] CIS_OFF_PC = 8'h0C;
  localparam logic [7:0] CIS_OFF_STATUS = 8'h10;
  localparam logic [7:0] CIS_OFF_FSEL = 8'h14;
  localparam logic [7:0] CIS_OFF_FDATA = 8'h18;
  localparam logic [7:0] CIS_OFF_STACK = 8'h1C;
  localparam logic [7:0] CIS_OFF_WDT = 8'h20;

  // command word fields
  localparam int CIS_CMD_OP_LSB = 0;
  localparam int CIS_CMD_FA_LSB = 3;
  localparam int CIS_CMD_DEST_BIT = 10;

  // status bit positions
  localparam int CIS_ST_ZERO = 0;
  localparam int CIS_ST_EXPIRY = 1;
  localparam int CIS_ST_SLEEP = 2;
  localparam int CIS_ST_BUSY = 3;

  // stack pointer occupies stack register bits 16 up
  localparam int CIS_STK_SP_LSB = 16;
  localparam int CIS_WDT_PRE_LSB = 8;

  localparam int CIS_FILE_DEPTH = 128;
  localparam int CIS_STACK_DEPTH = 16;

  localparam logic [1:0] CIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIS_RESP_SLVERR = 2'h2;

  localparam logic [7:0] CIS_ACC_RST = 8'h00;
  localparam logic [14:0] CIS_PC_RST = 15'h0000;
  localparam logic [7:0] CIS_WDT_MAX = 8'hFF;

  typedef enum logic [2:0] {
    CIS_OP_CALL_VIA_ACCUMULATOR = 3'h0,
    CIS_OP_CLEAR_FILE_REGISTER = 3'h1,
    CIS_OP_CLEAR_ACCUMULATOR = 3'h2,
    CIS_OP_WATCHDOG_KICK = 3'h3,
    CIS_OP_COMPLEMENT_FILE = 3'h4,
    CIS_OP_DECREMENT_FILE = 3'h5,
    CIS_OP_NOP6 = 3'h6,
    CIS_OP_NOP7 = 3'h7
  } cis_op_t;

  typedef struct packed {
    logic dest;
    logic [6:0] faddr;
    cis_op_t op;
  } cis_cmd_t;
endpackage : cis_pkg

// ==== verification/cis_core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module cis_core_props (
  input wire logic clock,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_AW_DROP: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready high after address taken");
  AST_W_DROP: assert property (s_axi_wvalid && s_axi_wready |=>
    !s_axi_wready) else $error("wready high after data taken");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  // busy core may add cycles, so bound is loose
  AST_B_BOUND: assert property (!s_axi_awready && !s_axi_wready &&
    !s_axi_bvalid |-> ##[1:8] s_axi_bvalid) else $error("write answer late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer not next cycle");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer moved");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read channel not freed");
endmodule : cis_core_props
bind cis_core cis_core_props u_props (.clock, .rstn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ==== verification/cis_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module cis_core_tb
  import cis_pkg::*;
();
  logic clock = 0;
  logic rstn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, dst;
  logic [1:0] bresp, rresp, rs;
  logic [14:0] pc;
  logic [14:0] stk [$];
  logic [7:0] acc = CIS_ACC_RST, v, r;
  logic [6:0] lat;
  logic [2:0] st;
  int n_mismatch = 0, checks = 0, cyc = 0, seed = 13024;
  int sp = 0, op, f;
  always #12.5 clock = ~clock;
  cis_core dut (.clock, .rstn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd(CIS_OFF_STATUS);
    `CHK("status_rst", 3'b110, d[2:0])
    rd(8'h24);
    `CHK("rresp", CIS_RESP_SLVERR, rs)
    `CHK("rdata", 32'h0, d)
    wr(CIS_OFF_STACK, 32'h0);
    `CHK("bresp", CIS_RESP_SLVERR, rs)
    for (int i = 0; i < 90; i++) begin
      d = $random(seed);
      op = d[31:16] % 8;
      f = d[14:8];
      dst = d[15];
      // lane 0 strobe off must leave the accumulator alone
      if (d[23]) acc = d[7:0];
      wstrb <= {3'h7, d[23]};
      wr(CIS_OFF_ACC, {24'h0, d[7:0]});
      wstrb <= 4'hF;
      wr(CIS_OFF_FSEL, {25'h0, f[6:0]});
      d = $random(seed);
      lat = d[6:0];
      // zero results need these operands
      v = (i % 4 == 0) ? 8'h01 : (i % 4 == 1) ? 8'hFF : d[15:8];
      wr(CIS_OFF_LATCH, {25'h0, lat});
      wr(CIS_OFF_FDATA, {24'h0, v});
      d = $random(seed);
      pc = d[14:0];
      st = d[18:16];
      wr(CIS_OFF_PC, {17'h0, pc});
      wr(CIS_OFF_STATUS, {29'h0, st});
      // status read lands on the second execution cycle
      fork
        wr(CIS_OFF_CMD, {21'h0, dst, f[6:0], op[2:0]});
        begin
          repeat (3) @(posedge clock);
          rd(CIS_OFF_STATUS);
        end
      join
      `CHK("busy_2nd", op == 0, d[CIS_ST_BUSY])
      case (op)
        0: begin
          stk.push_back(pc + 15'h1);
          if (stk.size() > 16) stk.pop_front();
          sp = (sp + 1) % 16;
          pc = {lat, acc};
        end
        1: begin
          v = 8'h00;
          st[0] = 1'b1;
        end
        2: begin
          acc = 8'h00;
          st[0] = 1'b1;
        end
        3: st[2:1] = 2'b11;
        4, 5: begin
          r = (op == 4) ? ~v : v - 8'h01;
          st[0] = (r == 8'h00);
          if (dst) v = r;
          else acc = r;
        end
        default: ;
      endcase
      if (op != 0) pc = pc + 15'h1;
      do rd(CIS_OFF_STATUS); while (d[CIS_ST_BUSY] !== 1'b0);
      `CHK("status", st, d[2:0])
      if (op == 3) begin
        rd(CIS_OFF_WDT);
        `CHK("wdt_count", 8'h00, d[7:0])
        `CHK("wdt_pre_low", 1'b1, d[15:8] < 8'h40)
      end
      rd(CIS_OFF_ACC);
      `CHK("acc", acc, d[7:0])
      rd(CIS_OFF_FDATA);
      `CHK("file", v, d[7:0])
      rd(CIS_OFF_PC);
      `CHK("pc", pc, d[14:0])
      rd(CIS_OFF_STACK);
      `CHK("sp", sp[3:0], d[19:16])
      if (stk.size() > 0) `CHK("stack_top", stk[$], d[14:0])
    end
    // second reset in mid-run must restore status, accumulator, pc and stack pointer
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(CIS_OFF_STATUS);
    `CHK("status_rst2", 3'b110, d[2:0])
    rd(CIS_OFF_ACC);
    `CHK("acc_rst", CIS_ACC_RST, d[7:0])
    rd(CIS_OFF_PC);
    `CHK("pc_rst", CIS_PC_RST, d[14:0])
    rd(CIS_OFF_STACK);
    `CHK("sp_rst", 4'h0, d[19:16])
    results();
  end
endmodule : cis_core_tb
`default_nettype wire
